// *** common/vpic_pkg.sv ***
// Purpose: shared constants and types of the vectored interrupt controller
// Assumes: 8-bit register port; 24 maskable request lines
// Notes: offsets are the byte addresses seen on the register port
package vpic_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_IRQ = 24;
    localparam int NUM_GROUPS = 6;
    localparam int NUM_LEVELS = 4;
    localparam int NUM_KEYPINS = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_EXT_PIN_FLAGS = 8'hA4;
    localparam logic [7:0] ADDR_EXT_PIN_EDGE_SELECT = 8'hA5;
    localparam logic [7:0] ADDR_IRQ_ENABLE_0 = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_ENABLE_1 = 8'hA9;
    localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'hAA;
    localparam logic [7:0] ADDR_IRQ_ENABLE_3 = 8'hAB;
    localparam logic [7:0] ADDR_KEYPIN_EDGE_SELECT_LOW = 8'hAE;
    localparam logic [7:0] ADDR_KEYPIN_EDGE_SELECT_HIGH = 8'hAF;
    localparam logic [7:0] ADDR_GROUP_PRIORITY_LOW_BITS = 8'hB8;
    localparam logic [7:0] ADDR_KEYPIN_FLAGS = 8'hE8;
    localparam logic [7:0] ADDR_GROUP_PRIORITY_HIGH_BITS = 8'hF8;

    // ****************************************
    // Reset values and writable bits
    // ****************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_0_MASK = 8'hBF;
    localparam logic [7:0] ENABLE_MASK = 8'h3F;
    localparam logic [7:0] PRIORITY_MASK = 8'h3F;
    localparam logic [7:0] EXT_FLAG_MASK = 8'h03;
    localparam logic [7:0] EXT_POL_MASK = 8'h0F;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int KEYPIN_GROUP_ENABLE_BIT = 5;
    localparam int EXT_PIN_B_ENABLE_BIT = 2;
    localparam int EXT_PIN_A_ENABLE_BIT = 1;
    localparam int SERIAL_IO_IRQ_ENABLE_BIT = 5;
    localparam int EXT_PIN_A_FLAG_BIT = 0;
    localparam int EXT_PIN_B_FLAG_BIT = 1;
    localparam int EXT_PIN_A_POL_LSB = 0;
    localparam int EXT_PIN_B_POL_LSB = 2;

    // ****************************************
    // Request numbers and vectors
    // ****************************************
    localparam logic [4:0] IRQ_EXT_PIN_A = 5'h01;
    localparam logic [4:0] IRQ_EXT_PIN_B = 5'h02;
    localparam logic [4:0] IRQ_KEYPIN = 5'h05;
    localparam logic [4:0] IRQ_SERIAL_IO = 5'h0B;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // Edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OFFER = 2'b10
    } offer_state_t;

    // Request offered to the core
    typedef struct packed {
        logic valid;
        logic [4:0] num;
        logic [15:0] vector;
        logic [7:0] vector_low_byte;
    } irq_offer_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Core sequencing strobes
    typedef struct packed {
        logic instr_last;
        logic irq_ack;
        logic return_from_interrupt;
        logic power_control_wr;
    } core_seq_t;

    // Whole state of the controller
    typedef struct packed {
        offer_state_t st;
        logic [3:0][7:0] irq_enable;
        logic [7:0] prio_lo;
        logic [7:0] prio_hi;
        logic [7:0] ext_pin_flags;
        logic [7:0] ext_pin_edge_select;
        logic [7:0] keypin_flags;
        logic [7:0] keypin_edge_select_low;
        logic [7:0] keypin_edge_select_high;
        logic [23:0] req_flags;
        logic [3:0] in_service;
        logic ext_pin_a_prev;
        logic ext_pin_b_prev;
        logic [7:0] keypins_prev;
        irq_offer_t offer;
        logic wake;
        logic [7:0] rdata;
    } ctrl_state_t;

endpackage

// *** core/vectored_irq_ctrl.sv ***
// Purpose: vectored priority interrupt controller for a small CPU core
// Assumes: all inputs synchronous to mclk; core drives one-cycle strobes
// Notes: one state struct, one always_comb, one always_ff
//
// The plain strobed port was chosen for this implementation.

// Functional notes
// (R1) Vector is 0x0003 plus 8n; reset 0x0000
// (R2) Group k holds requests k, k+6, k+12, k+18
// (R3) Level 3 highest, level 0 lowest
// (R4) Level = {high-bits reg bit, low-bits reg bit}
// (R5) Same level: lowest request number wins
// (R6) Simultaneous different levels: higher level first
// (R7) Take only with global and source enable
// (R8) Request flag sets, clears when service begins
// (R9) Pending until accepted, reset or software clear
// (R10) Sample at instruction end; ack next instruction
// (R11) Response 3 to 9 cycles; return ends service
// (R12) Preempt only by strictly higher level
// (R13) Any enabled source raises wake-up
// (R14) Hold requests while enable/priority/power written
// (R15) Pin flags set on edge, clear on entry/write
// (R16) Edge select picks rising, falling or both
// (R17) Codes: 00 none, 01 rise, 10 fall, 11 both
// (R18) Enable 0: global 7, key 5, pin b 2, pin a 1
// (R19) Enable bit n mod 6 of register n div 6
// (R20) Reset clears all registers to zero
// (R21) Global enable drops on entry, sets on return
// (R22) Offer number and valid; clear flag on ack
module vectored_irq_ctrl (
    input wire logic mclk,
    input wire logic rst_b,
    input wire vpic_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [23:0] periph_irq,
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    input wire logic [7:0] keypins,
    input wire vpic_pkg::core_seq_t core_seq,
    output vpic_pkg::irq_offer_t irq_offer,
    output logic [15:0] reset_vector,
    output logic wake_req
);

    // ****************************************
    // Helpers
    // ****************************************

    // Edge detector shared by every pin source
    function automatic logic edge_hit(input logic [1:0] pol,
                                      input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (pol)
            vpic_pkg::EDGE_RISE: edge_hit = rise; // [R16] [R17]
            vpic_pkg::EDGE_FALL: edge_hit = fall; // [R16] [R17]
            vpic_pkg::EDGE_BOTH: edge_hit = rise | fall; // [R17]
            default: edge_hit = 1'b0; // [R17]
        endcase
    endfunction

    // Entry address of request n
    function automatic logic [15:0] vector_of(input logic [4:0] n);
        vector_of = vpic_pkg::VECTOR_BASE + {8'h00, n, 3'b000}; // [R1]
    endfunction

    // Level of request n from its group's two priority bits
    function automatic logic [1:0] level_of(input logic [7:0] lo,
                                            input logic [7:0] hi,
                                            input int n);
        int g;
        g = n % vpic_pkg::NUM_GROUPS; // [R2]
        level_of = {hi[g], lo[g]}; // [R4]
    endfunction

    // Register read mux
    function automatic logic [7:0] read_reg(input vpic_pkg::ctrl_state_t s,
                                            input logic [7:0] a);
        case (a)
            vpic_pkg::ADDR_EXT_PIN_FLAGS: read_reg = s.ext_pin_flags;
            vpic_pkg::ADDR_EXT_PIN_EDGE_SELECT:
                read_reg = s.ext_pin_edge_select;
            vpic_pkg::ADDR_IRQ_ENABLE_0: read_reg = s.irq_enable[0];
            vpic_pkg::ADDR_IRQ_ENABLE_1: read_reg = s.irq_enable[1];
            vpic_pkg::ADDR_IRQ_ENABLE_2: read_reg = s.irq_enable[2];
            vpic_pkg::ADDR_IRQ_ENABLE_3: read_reg = s.irq_enable[3];
            vpic_pkg::ADDR_KEYPIN_EDGE_SELECT_LOW:
                read_reg = s.keypin_edge_select_low;
            vpic_pkg::ADDR_KEYPIN_EDGE_SELECT_HIGH:
                read_reg = s.keypin_edge_select_high;
            vpic_pkg::ADDR_GROUP_PRIORITY_LOW_BITS: read_reg = s.prio_lo;
            vpic_pkg::ADDR_KEYPIN_FLAGS: read_reg = s.keypin_flags;
            vpic_pkg::ADDR_GROUP_PRIORITY_HIGH_BITS: read_reg = s.prio_hi;
            default: read_reg = 8'h00; // Unmapped reads as zero
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    vpic_pkg::ctrl_state_t state_q;
    vpic_pkg::ctrl_state_t state_d;

    // Next-state logic
    always_comb begin
        logic wr;
        logic hold;
        logic global_en;
        logic found;
        logic [1:0] best_lvl;
        logic [4:0] best_num;
        logic [1:0] lvl;
        logic [23:0] pending;
        logic [23:0] enabled;
        logic [23:0] clr_req;
        logic [7:0] ext_set;
        logic [7:0] ext_clr;
        logic [7:0] key_set;
        logic [7:0] key_clr;
        logic [15:0] key_pol;
        logic [3:0] top_bit;
        wr = 1'b0;
        hold = 1'b0;
        global_en = 1'b0;
        found = 1'b0;
        best_lvl = 2'h0;
        best_num = 5'h00;
        lvl = 2'h0;
        pending = 24'h000000;
        enabled = 24'h000000;
        clr_req = 24'h000000;
        ext_set = 8'h00;
        ext_clr = 8'h00;
        key_set = 8'h00;
        key_clr = 8'h00;
        key_pol = 16'h0000;
        top_bit = 4'h0;
        state_d = state_q;
        wr = reg_req.wr;

        // Read data stands only in the cycle after the strobe
        state_d.rdata = reg_req.rd ? read_reg(state_q, reg_req.addr)
                                   : 8'h00;

        // Control register writes
        if (wr) begin
            case (reg_req.addr)
                vpic_pkg::ADDR_IRQ_ENABLE_0:
                    state_d.irq_enable[0] = reg_req.wdata &
                        vpic_pkg::ENABLE_0_MASK; // [R18]
                vpic_pkg::ADDR_IRQ_ENABLE_1:
                    state_d.irq_enable[1] = reg_req.wdata &
                        vpic_pkg::ENABLE_MASK; // [R19]
                vpic_pkg::ADDR_IRQ_ENABLE_2:
                    state_d.irq_enable[2] = reg_req.wdata &
                        vpic_pkg::ENABLE_MASK; // [R19]
                vpic_pkg::ADDR_IRQ_ENABLE_3:
                    state_d.irq_enable[3] = reg_req.wdata &
                        vpic_pkg::ENABLE_MASK; // [R19]
                vpic_pkg::ADDR_GROUP_PRIORITY_LOW_BITS:
                    state_d.prio_lo = reg_req.wdata &
                        vpic_pkg::PRIORITY_MASK;
                vpic_pkg::ADDR_GROUP_PRIORITY_HIGH_BITS:
                    state_d.prio_hi = reg_req.wdata &
                        vpic_pkg::PRIORITY_MASK;
                vpic_pkg::ADDR_EXT_PIN_EDGE_SELECT:
                    state_d.ext_pin_edge_select = reg_req.wdata &
                        vpic_pkg::EXT_POL_MASK;
                vpic_pkg::ADDR_KEYPIN_EDGE_SELECT_LOW:
                    state_d.keypin_edge_select_low = reg_req.wdata;
                vpic_pkg::ADDR_KEYPIN_EDGE_SELECT_HIGH:
                    state_d.keypin_edge_select_high = reg_req.wdata;
                vpic_pkg::ADDR_EXT_PIN_FLAGS:
                    ext_clr = ~reg_req.wdata; // [R15] [R9]
                vpic_pkg::ADDR_KEYPIN_FLAGS:
                    key_clr = ~reg_req.wdata; // [R15] [R9]
                default: begin
                end
            endcase
        end

        // Writes to enables, priorities or power control hold sampling
        if (wr) begin
            case (reg_req.addr)
                vpic_pkg::ADDR_IRQ_ENABLE_0,
                vpic_pkg::ADDR_IRQ_ENABLE_1,
                vpic_pkg::ADDR_IRQ_ENABLE_2,
                vpic_pkg::ADDR_IRQ_ENABLE_3,
                vpic_pkg::ADDR_GROUP_PRIORITY_LOW_BITS,
                vpic_pkg::ADDR_GROUP_PRIORITY_HIGH_BITS:
                    hold = 1'b1; // [R14]
                default: hold = 1'b0;
            endcase
        end
        hold = hold | core_seq.power_control_wr; // [R14]

        // Pin edge detection
        ext_set[vpic_pkg::EXT_PIN_A_FLAG_BIT] = edge_hit(
            state_q.ext_pin_edge_select[vpic_pkg::EXT_PIN_A_POL_LSB +: 2],
            state_q.ext_pin_a_prev, ext_pin_a); // [R15]
        ext_set[vpic_pkg::EXT_PIN_B_FLAG_BIT] = edge_hit(
            state_q.ext_pin_edge_select[vpic_pkg::EXT_PIN_B_POL_LSB +: 2],
            state_q.ext_pin_b_prev, ext_pin_b); // [R15]
        key_pol = {state_q.keypin_edge_select_high,
                   state_q.keypin_edge_select_low};
        for (int k = 0; k < vpic_pkg::NUM_KEYPINS; k++) begin
            key_set[k] = edge_hit(key_pol[2*k +: 2],
                                  state_q.keypins_prev[k],
                                  keypins[k]); // [R16]
        end
        state_d.ext_pin_a_prev = ext_pin_a;
        state_d.ext_pin_b_prev = ext_pin_b;
        state_d.keypins_prev = keypins;

        // Pending view: pin sources come from their own flags
        pending = state_q.req_flags;
        pending[vpic_pkg::IRQ_EXT_PIN_A] =
            state_q.ext_pin_flags[vpic_pkg::EXT_PIN_A_FLAG_BIT];
        pending[vpic_pkg::IRQ_EXT_PIN_B] =
            state_q.ext_pin_flags[vpic_pkg::EXT_PIN_B_FLAG_BIT];
        pending[vpic_pkg::IRQ_KEYPIN] = |state_q.keypin_flags;

        // Source enables: bit n mod 6 of register n div 6
        for (int n = 0; n < vpic_pkg::NUM_IRQ; n++) begin
            enabled[n] = state_q.irq_enable[n / 6][n % 6]; // [R19]
        end
        global_en = state_q.irq_enable[0][vpic_pkg::GLOBAL_IRQ_ENABLE_BIT];

        // Wake-up ignores global enable and priority
        state_d.wake = |(pending & enabled); // [R13]

        // Scan from high numbers down so ties keep the lowest number
        for (int n = vpic_pkg::NUM_IRQ - 1; n >= 0; n--) begin
            lvl = level_of(state_q.prio_lo, state_q.prio_hi, n);
            if (pending[n] && enabled[n] &&
                (!found || lvl >= best_lvl)) begin // [R3] [R5] [R6]
                found = 1'b1;
                best_lvl = lvl;
                best_num = 5'(n);
            end
        end
        // Only a strictly higher level than any in service may enter
        if (found && (state_q.in_service >> best_lvl) > 4'h1) begin
            found = 1'b0; // [R12]
        end else if (found && state_q.in_service[best_lvl]) begin
            found = 1'b0; // [R12]
        end
        found = found & global_en; // [R7]

        // Offer handshake with the core
        case (state_q.st)
            vpic_pkg::ST_IDLE: begin
                if (core_seq.instr_last && !hold && found) begin // [R10]
                    state_d.st = vpic_pkg::ST_OFFER;
                    state_d.offer.valid = 1'b1; // [R22]
                    state_d.offer.num = best_num;
                    state_d.offer.vector = vector_of(best_num); // [R1]
                    state_d.offer.vector_low_byte =
                        vector_of(best_num)[7:0]; // [R10]
                end
            end
            vpic_pkg::ST_OFFER: begin
                if (core_seq.irq_ack) begin // [R10] [R11]
                    state_d.st = vpic_pkg::ST_IDLE;
                    state_d.offer.valid = 1'b0;
                    clr_req[state_q.offer.num] = 1'b1; // [R8] [R22]
                    state_d.in_service[level_of(state_q.prio_lo,
                        state_q.prio_hi,
                        int'(state_q.offer.num))] = 1'b1; // [R12]
                    state_d.irq_enable[0][vpic_pkg::GLOBAL_IRQ_ENABLE_BIT]
                        = 1'b0; // [R21]
                    if (state_q.offer.num == vpic_pkg::IRQ_EXT_PIN_A) begin
                        ext_clr[vpic_pkg::EXT_PIN_A_FLAG_BIT] = 1'b1; // [R15]
                    end
                    if (state_q.offer.num == vpic_pkg::IRQ_EXT_PIN_B) begin
                        ext_clr[vpic_pkg::EXT_PIN_B_FLAG_BIT] = 1'b1; // [R15]
                    end
                    if (state_q.offer.num == vpic_pkg::IRQ_KEYPIN) begin
                        key_clr = 8'hFF; // [R15]
                    end
                end else if (core_seq.instr_last && !hold) begin
                    // Re-sample so a newer winner or a withdrawal counts
                    state_d.offer.valid = found; // [R10] [R9]
                    state_d.offer.num = best_num;
                    state_d.offer.vector = vector_of(best_num);
                    state_d.offer.vector_low_byte =
                        vector_of(best_num)[7:0];
                    state_d.st = found ? vpic_pkg::ST_OFFER
                                       : vpic_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d.st = vpic_pkg::ST_IDLE;
                state_d.offer.valid = 1'b0;
            end
        endcase

        // Return ends the innermost service and reopens global enable
        if (core_seq.return_from_interrupt) begin // [R11]
            for (int l = 0; l < vpic_pkg::NUM_LEVELS; l++) begin
                if (state_q.in_service[l]) begin
                    top_bit = 4'(1 << l);
                end
            end
            state_d.in_service = state_d.in_service & ~top_bit;
            state_d.irq_enable[0][vpic_pkg::GLOBAL_IRQ_ENABLE_BIT]
                = 1'b1; // [R21]
        end

        // Flag updates: a new event wins over a clear in the same cycle
        state_d.req_flags = (state_q.req_flags & ~clr_req) |
                            periph_irq; // [R8] [R9]
        state_d.ext_pin_flags = ((state_q.ext_pin_flags & ~ext_clr) |
                                 ext_set) & vpic_pkg::EXT_FLAG_MASK; // [R15]
        state_d.keypin_flags = (state_q.keypin_flags & ~key_clr) |
                               key_set; // [R15]
    end

    // ****************************************
    // Registers
    // ****************************************

    // Everything clears to zero; idle state is the only non-zero field
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0; // [R20]
            state_q.st <= vpic_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = state_q.rdata;
    assign irq_offer = state_q.offer;
    assign wake_req = state_q.wake;
    assign reset_vector = vpic_pkg::RESET_VECTOR; // [R1]

endmodule

// *** dv/vpic_checker.sv ***
// Purpose: port checks of the controller
// Assumes: one clock domain, reset active low
// Notes: bound at the foot of this file
module vpic_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire vpic_pkg::reg_req_t reg_req,
    input wire vpic_pkg::core_seq_t core_seq,
    input wire vpic_pkg::irq_offer_t irq_offer,
    input wire logic [15:0] reset_vector,
    input wire logic wake_req
);
    // ********
    // Helpers
    // ********
    logic hold_w;
    logic ok_w;
    // Writes that hold sampling
    assign hold_w = core_seq.power_control_wr | (reg_req.wr &
        (reg_req.addr inside {[8'hA8:8'hAB], 8'hB8, 8'hF8}));
    assign ok_w = irq_offer.valid;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ********
    // Properties
    // ********
    property p_vector;
        ok_w |-> irq_offer.vector == 16'h0003 + {8'h00, irq_offer.num, 3'h0};
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");
    property p_low_byte;
        ok_w |-> irq_offer.vector_low_byte == irq_offer.vector[7:0];
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte");
    property p_reset_vector;
        reset_vector == 16'h0000;
    endproperty
    a_reset_vector: assert property (p_reset_vector)
        else $error("reset vector");
    property p_sampled;
        $rose(ok_w) |-> $past(core_seq.instr_last);
    endproperty
    a_sampled: assert property (p_sampled) else $error("not sampled");
    property p_hold;
        $rose(ok_w) |-> !$past(hold_w);
    endproperty
    a_hold: assert property (p_hold) else $error("offer in hold");
    property p_ack;
        ok_w && core_seq.irq_ack |=> !ok_w [*2];
    endproperty
    a_ack: assert property (p_ack) else $error("no withdraw");
    property p_stands;
        ok_w && !core_seq.irq_ack && !core_seq.instr_last
            |=> ok_w && $stable(irq_offer.num);
    endproperty
    a_stands: assert property (p_stands) else $error("offer dropped");
    property p_wake;
        $rose(ok_w) |-> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule

bind vectored_irq_ctrl vpic_checker i_vpic_checker (.mclk(mclk),
    .rst_b(rst_b), .reg_req(reg_req), .core_seq(core_seq),
    .irq_offer(irq_offer), .reset_vector(reset_vector), .wake_req(wake_req));

// *** dv/core_model.sv ***
// Purpose: behavioural core that takes offers
// Assumes: four-cycle instructions
// Notes: ack_en low stalls the ack
module core_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ack_en,
    input wire logic rti_req,
    input wire logic pcw_req,
    input wire vpic_pkg::irq_offer_t irq_offer,
    output vpic_pkg::core_seq_t core_seq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] step_q;
    // Instruction step counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            step_q <= 2'h0;
        end else begin
            step_q <= step_q + 2'h1;
        end
    end
    // Sample last step, ack first step
    assign core_seq.instr_last = (step_q == 2'h3);
    assign core_seq.irq_ack = ack_en & irq_offer.valid &
        (step_q == 2'h0);
    assign core_seq.return_from_interrupt = rti_req;
    assign core_seq.power_control_wr = pcw_req;
endmodule

// *** dv/vectored_priority_interrupt_controller_test.sv ***
// Purpose: self-checking bench of the controller
// Assumes: core acks while ack_en is high
// Notes: winner comes from an integer model
module vectored_priority_interrupt_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    vpic_pkg::reg_req_t rq = '0;
    logic [23:0] pirq = 24'h0;
    logic pa = 1'b0;
    logic pb = 1'b0;
    logic [7:0] keys = 8'h00;
    logic ack_en = 1'b0;
    logic rti = 1'b0;
    logic pcw = 1'b0;
    logic [7:0] rdata;
    logic [15:0] rvec;
    logic wake;
    vpic_pkg::core_seq_t cs;
    vpic_pkg::irq_offer_t off;
    logic [23:0] pend = 24'h0;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 94;
    int lo, hi, r;
    logic [7:0] adr_tab [11] = '{8'hA4, 8'hA5, 8'hA8, 8'hA9, 8'hAA, 8'hAB,
        8'hAE, 8'hAF, 8'hB8, 8'hE8, 8'hF8};
    logic [7:0] msk_tab [11] = '{8'h00, 8'h0F, 8'hBF, 8'h3F, 8'h3F, 8'h3F,
        8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h3F};
    // Free-running clock
    always #50 mclk = ~mclk;
    // Rare power-control writes stress the hold-off
    always @(posedge mclk) pcw <= (($random(seed) & 7) == 0);
    vectored_irq_ctrl i_vectored_irq_ctrl (.mclk(mclk), .rst_b(rst_b),
        .reg_req(rq), .reg_rdata(rdata), .periph_irq(pirq), .ext_pin_a(pa),
        .ext_pin_b(pb), .keypins(keys), .core_seq(cs), .irq_offer(off),
        .reset_vector(rvec), .wake_req(wake));
    core_model i_core_model (.mclk(mclk), .rst_b(rst_b), .ack_en(ack_en),
        .rti_req(rti), .pcw_req(pcw), .irq_offer(off), .core_seq(cs));
    // ********
    // Tasks
    // ********
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        rq.addr <= a;
        rq.wdata <= v;
        rq.wr <= 1'b1;
        @(posedge mclk);
        rq.wr <= 1'b0;
    endtask
    // Data stands one cycle after strobe
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rq.addr <= a;
        rq.rd <= 1'b1;
        @(posedge mclk);
        rq.rd <= 1'b0;
        #1 chk(16'(rdata), 16'(exp));
    endtask
    task pulse(input int n);
        @(posedge mclk);
        pirq[n] <= 1'b1;
        @(posedge mclk);
        pirq[n] <= 1'b0;
        pend[n] = 1'b1;
    endtask
    task ret();
        @(posedge mclk);
        rti <= 1'b1;
        @(posedge mclk);
        rti <= 1'b0;
    endtask
    task pins(input logic v);
        @(posedge mclk);
        pa <= v;
        pb <= v;
        repeat (2) @(posedge mclk);
    endtask
    task automatic offer(input int n);
        #1;
        repeat (20) if (off.valid !== 1'b1) @(posedge mclk) #1;
        chk(16'(off.valid), 16'h1);
        chk(16'(off.num), 16'(n));
        chk(off.vector, 16'h0003 + 16'(8 * n));
        pend[n] = 1'b0;
        @(posedge mclk);
    endtask
    // Three sample points, no offer
    task automatic none();
        logic seen = 1'b0;
        repeat (12) @(posedge mclk) #1 seen |= off.valid;
        chk(16'(seen), 16'h0);
    endtask
    function automatic int pick();
        int b;
        int bl;
        int l;
        b = 0;
        bl = -1;
        for (int n = 0; n < 24; n++) begin
            l = 2 * ((hi >> (n % 6)) & 1) + ((lo >> (n % 6)) & 1);
            if (pend[n] === 1'b1 && l > bl) begin
                b = n;
                bl = l;
            end
        end
        return b;
    endfunction
    task wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, far past the run
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 11; i++) rchk(adr_tab[i], 8'h00);
        chk(rvec, 16'h0000);
        for (int i = 0; i < 11; i++) begin
            r = $random(seed);
            wr(adr_tab[i], r[7:0]);
            rchk(adr_tab[i], r[7:0] & msk_tab[i]);
        end
        wr(8'hA6, 8'hFF);
        rchk(8'hA6, 8'h00);
        $display("register test done");
        ack_en <= 1'b1;
        for (int i = 0; i < 4; i++) wr(adr_tab[i + 2], 8'hFF);
        repeat (6) begin
            lo = $random(seed) & 63;
            hi = $random(seed) & 63;
            wr(8'hB8, lo[7:0]);
            wr(8'hF8, hi[7:0]);
            r = $random(seed) & 32'h00FFFFD9;
            @(posedge mclk);
            pirq <= r[23:0];
            pend = r[23:0];
            @(posedge mclk);
            pirq <= 24'h0;
            while (pend !== 24'h0) begin
                offer(pick());
                ret();
            end
        end
        $display("priority test done");
        lo = 2;
        hi = 2;
        wr(8'hB8, 8'h02);
        wr(8'hF8, 8'h02);
        pulse(6);
        offer(6);
        wr(8'hA8, 8'hFF);
        pulse(12);
        none();
        pulse(7);
        offer(7);
        ret();
        none();
        ret();
        offer(12);
        ret();
        $display("nesting test done");
        wr(8'hA8, 8'hFF);
        wr(8'hAA, 8'h3D);
        pulse(13);
        none();
        chk(16'(wake), 16'h0);
        wr(8'hA8, 8'h3F);
        wr(8'hAA, 8'h3F);
        repeat (2) @(posedge mclk);
        #1 chk(16'(wake), 16'h1);
        none();
        wr(8'hA8, 8'hFF);
        offer(13);
        ret();
        $display("enable test done");
        wr(8'hA8, 8'h3F);
        for (int c = 0; c < 4; c++) begin
            wr(8'hA5, 8'(c * 5));
            pins(1'b1);
            rchk(8'hA4, 8'((c & 1) * 3));
            wr(8'hA4, 8'h00);
            pins(1'b0);
            rchk(8'hA4, 8'((c >> 1) * 3));
            wr(8'hA4, 8'h00);
        end
        wr(8'hAE, 8'hFF);
        wr(8'hAF, 8'hFF);
        r = $random(seed) | 1;
        @(posedge mclk);
        keys <= r[7:0];
        repeat (2) @(posedge mclk);
        rchk(8'hE8, r[7:0]);
        pend[5] = 1'b1;
        wr(8'hA8, 8'hFF);
        offer(5);
        rchk(8'hE8, 8'h00);
        ret();
        $display("pin test done");
        wrap_up();
    end
endmodule
